// ---- design/gpc_cfg.svh ----
// gpio pin configuration block: offsets, fields, resets and counts
// assumes an APB word bus; every printed offset is a register index
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// register indices; byte address is four times the index
`define GPC_OUT_CFG_IDX 16'hA100
`define GPC_IN_CFG_IDX 16'hA110
`define GPC_FUNC_SEL_IDX 16'hA120
`define GPC_BANK_IDX_W 16

// output config fields
`define GPC_OC_IN_INV 7
`define GPC_OC_HI_DRV 6
`define GPC_OC_LO_DRV 5
`define GPC_OC_OUT_INV 4
`define GPC_OC_ANA_B 3
`define GPC_OC_ANA_A 2
`define GPC_OC_PULLUP 1
`define GPC_OC_PULLDN 0

// input config fields (write view; read view differs in bits 5:4 and 2:0)
`define GPC_IC_IRQ_B 7
`define GPC_IC_IRQ_A 6
`define GPC_IC_RISE 5
`define GPC_IC_FALL 4
`define GPC_IC_INBUF 3
`define GPC_IC_CHECK 2
`define GPC_IC_FILT_HI 1
`define GPC_IC_FILT_LO 0

`define GPC_CFG_RESET 8'h00

// filter lengths in slow clock periods
`define GPC_FILT_SHORT 7'h04
`define GPC_FILT_MID 7'h10
`define GPC_FILT_LONG 7'h40

// drive check delay in system clocks
`define GPC_CHECK_DELAY 3

`endif

// ---- design/gpc_pkg.sv ----
// gpio pin configuration block: shared types
// assumes gpc_cfg.svh supplies the numeric constants
package gpc_pkg;

    typedef logic [7:0] gpc_byte_t;

    typedef enum logic [1:0] {
        GPC_FILT_OFF = 2'h0,
        GPC_FILT_4 = 2'h1,
        GPC_FILT_16 = 2'h2,
        GPC_FILT_64 = 2'h3
    } gpc_filt_t;

    typedef enum logic [2:0] {
        GPC_BANK_OUT = 3'h1,
        GPC_BANK_IN = 3'h2,
        GPC_BANK_FUNC = 3'h4
    } gpc_bank_t;

endpackage : gpc_pkg

// ---- design/gpc_top.sv ----
// gpio pin configuration block: per-pin pad control, input filter,
// edge flags, drive check and the APB register file
// assumes pad inputs and slow_tick_i are synchronous to mclk_i;
// slow_tick_i pulses once per slow oscillator period
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"

module gpc_top
    import gpc_pkg::*;
#(
    parameter int PINS = 16,
    parameter int AW = 18
) (
    // clock, reset, enable
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // pads
    input wire logic [PINS-1:0] pad_i,
    output logic [PINS-1:0] pad_o,
    output logic [PINS-1:0] high_driver_enable_o,
    output logic [PINS-1:0] low_driver_enable_o,
    output logic [PINS-1:0] pullup_enable_o,
    output logic [PINS-1:0] pulldown_enable_o,
    output logic [PINS-1:0] analog_mux_a_enable_o,
    output logic [PINS-1:0] analog_mux_b_enable_o,
    // core side
    input wire logic slow_tick_i,
    input wire logic [PINS-1:0] out_value_i,
    output logic [PINS-1:0] filtered_level_o,
    output logic [PINS*8-1:0] function_select_o,
    output logic pin_irq_a_o,
    output logic pin_irq_b_o
);

    gpc_byte_t ocfg [PINS];
    gpc_byte_t fsel [PINS];
    logic [PINS-1:0] irq_a_en, irq_b_en, rise_en, fall_en;
    logic [PINS-1:0] inbuf_en, check_en;
    logic [1:0] filt_sel [PINS];
    logic [PINS-1:0] rise_flag, fall_flag, check_flag;
    logic [PINS-1:0] raw_meta, raw_level, filtered, filt_prev;
    logic [6:0] filt_cnt [PINS];
    logic [PINS-1:0] drive_prev, pad_sample;
    logic [PINS-1:0] check_pipe [`GPC_CHECK_DELAY];
    logic [PINS-1:0] buf_out, next_pad;
    logic [PINS-1:0] rise_ev, fall_ev, err_ev;
    logic acc, wr_acc;
    gpc_bank_t bank;
    logic bank_hit;
    logic [3:0] pin_sel;

    function automatic logic [6:0] filt_len(input logic [1:0] sel);
        case (gpc_filt_t'(sel))
            GPC_FILT_4: filt_len = `GPC_FILT_SHORT;
            GPC_FILT_16: filt_len = `GPC_FILT_MID;
            GPC_FILT_64: filt_len = `GPC_FILT_LONG;
            default: filt_len = 7'h00;
        endcase
    endfunction : filt_len

    // word index split into bank; result bit 3 flags a mapped address
    // widened to 32 bits so the upper-bit test stays legal at any AW
    function automatic logic [3:0] decode(input logic [AW-1:0] addr);
        logic [31:0] wide;
        logic [11:0] top;
        wide = 32'(addr);
        top = wide[`GPC_BANK_IDX_W+1:6];
        decode = {1'b0, GPC_BANK_OUT};
        if (wide[31:`GPC_BANK_IDX_W+2] == '0) begin
            if (top == 12'(`GPC_OUT_CFG_IDX >> 4)) begin
                decode = {1'b1, GPC_BANK_OUT};
            end else if (top == 12'(`GPC_IN_CFG_IDX >> 4)) begin
                decode = {1'b1, GPC_BANK_IN};
            end else if (top == 12'(`GPC_FUNC_SEL_IDX >> 4)) begin
                decode = {1'b1, GPC_BANK_FUNC};
            end
        end
    endfunction : decode

    always_comb begin
        logic [3:0] hit;
        hit = decode(paddr_i);
        bank = gpc_bank_t'(hit[2:0]);
        bank_hit = hit[3];
        pin_sel = paddr_i[5:2];
    end

    // one wait state: pready rises in the second access cycle
    assign acc = psel_i & penable_i & pready_o;
    assign wr_acc = acc & pwrite_i & bank_hit;

    // pad path: buffer forced low when disabled, invert ahead of it
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            buf_out[i] = inbuf_en[i] & (pad_i[i] ^ ocfg[i][`GPC_OC_IN_INV]);
            next_pad[i] = out_value_i[i] ^ ocfg[i][`GPC_OC_OUT_INV];
            rise_ev[i] = filtered[i] & ~filt_prev[i];
            fall_ev[i] = ~filtered[i] & filt_prev[i];
            err_ev[i] = check_en[i] & check_pipe[`GPC_CHECK_DELAY-1][i]
                        & (pad_sample[i] != pad_o[i]);
        end
    end

    // apb handshake
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            pready_o <= psel_i & penable_i & ~pready_o;
            pslverr_o <= psel_i & penable_i & ~pready_o & ~bank_hit;
            if (psel_i & penable_i & ~pready_o) begin
                prdata_o <= 32'h0000_0000;
                if (bank_hit && !pwrite_i) begin
                    case (bank)
                        GPC_BANK_OUT: prdata_o[7:0] <= ocfg[pin_sel];
                        GPC_BANK_IN: prdata_o[7:0] <= {irq_b_en[pin_sel],
                            irq_a_en[pin_sel], rise_flag[pin_sel],
                            fall_flag[pin_sel], inbuf_en[pin_sel],
                            check_flag[pin_sel], filtered[pin_sel],
                            raw_level[pin_sel]};
                        GPC_BANK_FUNC: prdata_o[7:0] <= fsel[pin_sel];
                        default: prdata_o[7:0] <= 8'h00;
                    endcase
                end
            end
        end
    end

    // configuration banks, index n belongs to pin n
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < PINS; i++) begin
                ocfg[i] <= `GPC_CFG_RESET;
                fsel[i] <= `GPC_CFG_RESET;
                filt_sel[i] <= 2'h0;
            end
            irq_a_en <= '0;
            irq_b_en <= '0;
            rise_en <= '0;
            fall_en <= '0;
            inbuf_en <= '0;
            check_en <= '0;
        end else if (ce_i && wr_acc) begin
            case (bank)
                GPC_BANK_OUT: ocfg[pin_sel] <= pwdata_i[7:0];
                GPC_BANK_FUNC: fsel[pin_sel] <= pwdata_i[7:0];
                GPC_BANK_IN: begin
                    irq_b_en[pin_sel] <= pwdata_i[`GPC_IC_IRQ_B];
                    irq_a_en[pin_sel] <= pwdata_i[`GPC_IC_IRQ_A];
                    rise_en[pin_sel] <= pwdata_i[`GPC_IC_RISE];
                    fall_en[pin_sel] <= pwdata_i[`GPC_IC_FALL];
                    inbuf_en[pin_sel] <= pwdata_i[`GPC_IC_INBUF];
                    check_en[pin_sel] <= pwdata_i[`GPC_IC_CHECK];
                    filt_sel[pin_sel] <=
                        pwdata_i[`GPC_IC_FILT_HI:`GPC_IC_FILT_LO];
                end
                default: ;
            endcase
        end
    end

    // pad drive; the pin is sampled apart from the value register, so checks see real data
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pad_o <= '0;
            drive_prev <= '0;
            pad_sample <= '0;
        end else if (ce_i) begin
            pad_o <= next_pad;
            drive_prev <= pad_o;
            pad_sample <= pad_i;
        end
    end

    // two-stage sync, then filter counting slow ticks
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            raw_meta <= '0;
            raw_level <= '0;
            filtered <= '0;
            filt_prev <= '0;
            for (int i = 0; i < PINS; i++) begin
                filt_cnt[i] <= 7'h00;
            end
        end else if (ce_i) begin
            raw_meta <= buf_out;
            raw_level <= raw_meta;
            filt_prev <= filtered;
            for (int i = 0; i < PINS; i++) begin
                if (filt_len(filt_sel[i]) == 7'h00) begin
                    filtered[i] <= raw_level[i];
                    filt_cnt[i] <= 7'h00;
                end else if (raw_level[i] == filtered[i]) begin
                    filt_cnt[i] <= 7'h00;
                end else if (slow_tick_i) begin
                    // restarts on any bounce back to the old level
                    if (filt_cnt[i] + 7'h01 >= filt_len(filt_sel[i])) begin
                        filtered[i] <= raw_level[i];
                        filt_cnt[i] <= 7'h00;
                    end else begin
                        filt_cnt[i] <= filt_cnt[i] + 7'h01;
                    end
                end
            end
        end
    end

    // edge latches; a new edge wins over a clearing write
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            rise_flag <= '0;
            fall_flag <= '0;
        end else if (ce_i) begin
            for (int i = 0; i < PINS; i++) begin
                if (rise_ev[i] && rise_en[i] && (irq_a_en[i] || irq_b_en[i]))
                    rise_flag[i] <= 1'b1;
                else if (wr_acc && bank == GPC_BANK_IN && pin_sel == i[3:0]
                         && !pwdata_i[`GPC_IC_RISE])
                    rise_flag[i] <= 1'b0;
                if (fall_ev[i] && fall_en[i] && (irq_a_en[i] || irq_b_en[i]))
                    fall_flag[i] <= 1'b1;
                else if (wr_acc && bank == GPC_BANK_IN && pin_sel == i[3:0]
                         && !pwdata_i[`GPC_IC_FALL])
                    fall_flag[i] <= 1'b0;
            end
        end
    end

    // drive check: change marker travels three clocks, then compare
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int k = 0; k < `GPC_CHECK_DELAY; k++) begin
                check_pipe[k] <= '0;
            end
            check_flag <= '0;
        end else if (ce_i) begin
            check_pipe[0] <= (pad_o ^ drive_prev) & check_en;
            for (int k = 1; k < `GPC_CHECK_DELAY; k++) begin
                check_pipe[k] <= check_pipe[k-1] & check_en;
            end
            for (int i = 0; i < PINS; i++) begin
                if (!check_en[i])
                    check_flag[i] <= 1'b0;
                else if (err_ev[i])
                    check_flag[i] <= 1'b1;
            end
        end
    end

    // interrupt lines from latched flags of enabled pins
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_irq_a_o <= 1'b0;
            pin_irq_b_o <= 1'b0;
        end else if (ce_i) begin
            pin_irq_a_o <= |(irq_a_en & (rise_flag | fall_flag | check_flag));
            pin_irq_b_o <= |(irq_b_en & (rise_flag | fall_flag | check_flag));
        end
    end

    generate
        for (genvar g = 0; g < PINS; g++) begin : g_pin
            assign high_driver_enable_o[g] = ocfg[g][`GPC_OC_HI_DRV];
            assign low_driver_enable_o[g] = ocfg[g][`GPC_OC_LO_DRV];
            assign pullup_enable_o[g] = ocfg[g][`GPC_OC_PULLUP];
            assign pulldown_enable_o[g] = ocfg[g][`GPC_OC_PULLDN];
            assign analog_mux_a_enable_o[g] = ocfg[g][`GPC_OC_ANA_A];
            assign analog_mux_b_enable_o[g] = ocfg[g][`GPC_OC_ANA_B];
            assign function_select_o[g*8 +: 8] = fsel[g];
        end
    endgenerate
    assign filtered_level_o = filtered;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence out0_write_s;
        ce_i && wr_acc && bank == GPC_BANK_OUT && pin_sel == 4'h0;
    endsequence

    sequence pin1_change_s;
        ce_i && check_en[1] && (pad_o[1] != drive_prev[1]);
    endsequence

    // the change marker only survives while the check stays enabled
    sequence pin1_settle_s;
        (ce_i && check_en[1])[*2];
    endsequence

    hiz_hold_a: assert property (
        !high_driver_enable_o[0] && !low_driver_enable_o[0]
        && !(wr_acc && bank == GPC_BANK_OUT && pin_sel == 4'h0)
        |=> !high_driver_enable_o[0] && !low_driver_enable_o[0])
        else $error("pin 0 driver enabled without a write");

    wr_land_a: assert property (
        out0_write_s |=> ocfg[0] == $past(pwdata_i[7:0]))
        else $error("output config write lost");

    fsel_land_a: assert property (
        ce_i && wr_acc && bank == GPC_BANK_FUNC && pin_sel == 4'h0
        |=> function_select_o[7:0] == $past(pwdata_i[7:0]))
        else $error("function select write lost");

    rise_latch_a: assert property (
        ce_i && rise_ev[0] && rise_en[0]
        && (irq_a_en[0] || irq_b_en[0]) |=> rise_flag[0])
        else $error("rise edge not latched");

    fall_latch_a: assert property (
        ce_i && fall_ev[0] && fall_en[0]
        && (irq_a_en[0] || irq_b_en[0]) |=> fall_flag[0])
        else $error("fall edge not latched");

    rise_clear_a: assert property (
        ce_i && wr_acc && bank == GPC_BANK_IN
        && pin_sel == 4'h0 && !pwdata_i[`GPC_IC_RISE] && !rise_ev[0]
        |=> !rise_flag[0])
        else $error("rise flag not cleared by write");

    check_clear_a: assert property (
        ce_i && !check_en[1] |=> !check_flag[1])
        else $error("drive check flag set while disabled");

    check_delay_a: assert property (
        pin1_change_s ##1 pin1_settle_s
        ##1 (ce_i && check_en[1] && pad_sample[1] != pad_o[1])
        |=> check_flag[1] || !check_en[1])
        else $error("drive mismatch not flagged");

    inbuf_off_a: assert property (
        (ce_i && !inbuf_en[0])[*3] |-> !raw_level[0])
        else $error("raw level high with buffer off");

    filt_hold_a: assert property (
        ce_i && filt_len(filt_sel[2]) != 7'h00 && !slow_tick_i
        |=> filtered[2] == $past(filtered[2]))
        else $error("filtered level moved between slow ticks");

    pad_invert_a: assert property (
        ce_i |=> pad_o[0] ==
        ($past(out_value_i[0]) ^ $past(ocfg[0][`GPC_OC_OUT_INV])))
        else $error("pad value wrong polarity");

    irq_gate_a: assert property (
        ce_i && check_flag[1] && irq_a_en == '0 |=> !pin_irq_a_o)
        else $error("interrupt a raised while disabled");

    check_irq_a: assert property (
        ce_i && check_flag[1] && irq_a_en[1] |=> pin_irq_a_o)
        else $error("drive mismatch did not raise interrupt a");

    apb_wait_a: assert property (
        psel_i && penable_i && !pready_o && ce_i
        |=> pready_o ##1 !pready_o)
        else $error("apb ready timing wrong");

endmodule : gpc_top
`default_nettype wire

// ---- bench/gpc_pad_model.sv ----
// pad model: the board side of every gpio pin
// assumes the bench supplies the external level and a fault mask
`timescale 1ns/10ps
`default_nettype none

module gpc_pad_model #(
    parameter int PINS = 16
) (
    // from the block
    input wire logic [PINS-1:0] drv_data_i,
    input wire logic [PINS-1:0] hi_en_i,
    input wire logic [PINS-1:0] lo_en_i,
    input wire logic [PINS-1:0] pu_i,
    input wire logic [PINS-1:0] pd_i,
    // board side
    input wire logic [PINS-1:0] ext_i,
    input wire logic [PINS-1:0] fault_i,
    output logic [PINS-1:0] level_o
);
    // a driver only wins toward the rail it owns; fault mimics a short
    always_comb begin
        for (int n = 0; n < PINS; n++) begin
            if ((hi_en_i[n] && drv_data_i[n]) || (lo_en_i[n] && !drv_data_i[n]))
                level_o[n] = drv_data_i[n] ^ fault_i[n];
            else if (pu_i[n])
                level_o[n] = 1'b1;
            else if (pd_i[n])
                level_o[n] = 1'b0;
            else
                level_o[n] = ext_i[n];
        end
    end
endmodule : gpc_pad_model

`default_nettype wire

// ---- bench/testbench.sv ----
// testbench: gpio pin configuration block over apb
// assumes gpc_top answers each access with one wait state
`timescale 1ns/10ps
`default_nettype none
`include "gpc_cfg.svh"

module testbench;
    logic mclk_i, rst_i, psel, penable, pwrite, pready, pslverr, tick;
    logic ce;
    logic irq_a, irq_b;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] pad, pad_o, hi, lo, pu, pd, ama, amb, ext, fault, outv;
    logic [15:0] filt;
    logic [127:0] fsel;
    logic e;
    int errors, total_checks, nt;

    gpc_top #(.PINS(16), .AW(18)) DUT (.mclk_i(mclk_i), .rst_i(rst_i),
        .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pad_i(pad), .pad_o(pad_o),
        .high_driver_enable_o(hi), .low_driver_enable_o(lo),
        .pullup_enable_o(pu), .pulldown_enable_o(pd),
        .analog_mux_a_enable_o(ama), .analog_mux_b_enable_o(amb),
        .slow_tick_i(tick), .out_value_i(outv), .filtered_level_o(filt),
        .function_select_o(fsel), .pin_irq_a_o(irq_a), .pin_irq_b_o(irq_b));

    gpc_pad_model #(.PINS(16)) pads (.drv_data_i(pad_o), .hi_en_i(hi),
        .lo_en_i(lo), .pu_i(pu), .pd_i(pd), .ext_i(ext), .fault_i(fault),
        .level_o(pad));

    task end_of_test;
        if (errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // automatic: the tick process and the main sequence both call it
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc

    // entered just after a rising edge; leaves one idle cycle behind
    task apb(input logic wr, input int idx, input int d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx[15:0], 2'b00};
        pwdata <= {24'h000000, d[7:0]};
        @(posedge mclk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_i);
    endtask : apb

    task rd(input int idx, input int exp);
        apb(1'b0, idx, 0);
        chk(r, {24'h000000, exp[7:0]});
    endtask : rd

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // slow oscillator tick every fourth system clock
    initial begin
        tick = 1'b0;
        forever begin
            cyc(3);
            tick <= 1'b1;
            cyc(1);
            tick <= 1'b0;
        end
    end

    initial begin
        errors = 0;
        total_checks = 0;
        rst_i = 1'b1;
        ce = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 18'h00000;
        pwdata = 32'h00000000;
        {ext, fault, outv} = 48'h000000000000;
        cyc(8);
        rst_i <= 1'b0;
        cyc(1);
        chk({hi, lo}, 32'h0);
        chk({pu, pd, ama, amb}, 32'h0);
        for (int n = 0; n < 16; n++) begin
            rd(`GPC_OUT_CFG_IDX + n, 8'h00);
            rd(`GPC_IN_CFG_IDX + n, 8'h00);
            rd(`GPC_FUNC_SEL_IDX + n, 8'h00);
        end
        for (int n = 0; n < 16; n++) begin
            apb(1'b1, `GPC_OUT_CFG_IDX + n, n < 8 ? 8'h01 << n : 8'hFF);
            apb(1'b1, `GPC_FUNC_SEL_IDX + n, 8'hA0 + n);
        end
        chk({pd, pu}, 32'hFF01FF02);
        chk({ama, amb}, 32'hFF04FF08);
        chk({lo, hi}, 32'hFF20FF40);
        chk(pad_o, 16'hFF10);
        for (int n = 0; n < 16; n++) begin
            rd(`GPC_OUT_CFG_IDX + n, n < 8 ? 8'h01 << n : 8'hFF);
            rd(`GPC_FUNC_SEL_IDX + n, 8'hA0 + n);
            chk(fsel[8*n +: 8], 8'hA0 + n);
        end
        apb(1'b0, 16'h0000, 8'h00);
        chk(r, 32'h00000000);
        chk(e, 1'b1);
        // second reset in mid-run must undo every pad setting
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        cyc(2);
        chk({hi, lo}, 32'h0);
        chk({pu, pd}, 32'h0);
        chk({ama, amb}, 32'h0);
        // input buffer gate, raw and filtered status, invert
        ext[0] <= 1'b1;
        cyc(4);
        rd(`GPC_IN_CFG_IDX, 8'h00);
        apb(1'b1, `GPC_IN_CFG_IDX, 8'h08);
        cyc(4);
        rd(`GPC_IN_CFG_IDX, 8'h0B);
        chk(filt[0], 1'b1);
        apb(1'b1, `GPC_OUT_CFG_IDX, 8'h80);
        cyc(4);
        rd(`GPC_IN_CFG_IDX, 8'h08);
        apb(1'b1, `GPC_OUT_CFG_IDX, 8'h00);
        // edge flags and their clearing writes
        apb(1'b1, `GPC_IN_CFG_IDX, 8'h78);
        ext[0] <= 1'b0;
        cyc(6);
        rd(`GPC_IN_CFG_IDX, 8'h58);
        chk({irq_b, irq_a}, 2'h1);
        apb(1'b1, `GPC_IN_CFG_IDX, 8'h68);
        rd(`GPC_IN_CFG_IDX, 8'h48);
        chk({irq_b, irq_a}, 2'h0);
        apb(1'b1, `GPC_IN_CFG_IDX, 8'hB8);
        ext[0] <= 1'b1;
        cyc(6);
        rd(`GPC_IN_CFG_IDX, 8'hAB);
        chk({irq_b, irq_a}, 2'h2);
        apb(1'b1, `GPC_IN_CFG_IDX, 8'h98);
        rd(`GPC_IN_CFG_IDX, 8'h8B);
        // drive check on pin 1: clean toggle, then a shorted pad
        apb(1'b1, `GPC_OUT_CFG_IDX + 1, 8'h60);
        apb(1'b1, `GPC_IN_CFG_IDX + 1, 8'h0C);
        outv[1] <= 1'b1;
        cyc(8);
        rd(`GPC_IN_CFG_IDX + 1, 8'h0B);
        fault[1] <= 1'b1;
        outv[1] <= 1'b0;
        cyc(8);
        rd(`GPC_IN_CFG_IDX + 1, 8'h0F);
        chk({irq_b, irq_a}, 2'h0);
        apb(1'b1, `GPC_IN_CFG_IDX + 1, 8'h4C);
        cyc(3);
        chk(irq_a, 1'b1);
        apb(1'b1, `GPC_IN_CFG_IDX + 1, 8'h48);
        rd(`GPC_IN_CFG_IDX + 1, 8'h4B);
        chk(irq_a, 1'b0);
        // filter lengths 4, 16 and 64 slow ticks on pin 2
        for (int s = 1; s < 4; s++) begin
            nt = 4 << (2 * (s - 1));
            apb(1'b1, `GPC_IN_CFG_IDX + 2, 8'h08 | s[7:0]);
            cyc(4 * nt + 16);
            ext[2] <= ~ext[2];
            cyc((nt - 2) * 4);
            chk(filt[2], {~ext[2]});
            cyc(16);
            chk(filt[2], ext[2]);
        end
        // clock enable low must freeze the filtered level on pin 0
        ce <= 1'b0;
        ext[0] <= 1'b0;
        cyc(6);
        chk(filt[0], 1'b1);
        ce <= 1'b1;
        cyc(6);
        chk(filt[0], 1'b0);
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
